/* File: sais_pkg.sv */
// Package for the stack and interrupt sequencer: register layout, commands, states
`default_nettype none
package sais_pkg;
	localparam int NUM_SRC = 8;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam int PAGE_SEL_BIT = 0;
	localparam logic [7:0] PAGE_RSVD_MASK = 8'hFE;
	localparam logic [15:0] VEC_BASE_APP = 16'h0000;
	localparam logic [15:0] VEC_BASE_BOOT_DEF = 16'hF000;
	localparam logic [15:0] VEC_STRIDE = 16'h0002;
	localparam logic [15:0] SP_ONE = 16'h0001;
	localparam logic [15:0] SP_TWO = 16'h0002;
	localparam int T_CLK_NS = 25;
	localparam int ENTRY_CYCLES = 4;
	localparam int EXIT_CYCLES = 4;
	localparam int WAKE_CYCLES = 4;
	localparam logic [3:0] CNT_ENTRY = 4'(ENTRY_CYCLES - 1);
	localparam logic [3:0] CNT_EXIT = 4'(EXIT_CYCLES - 1);
	localparam logic [3:0] CNT_WAKE = 4'(WAKE_CYCLES);

	// Instruction sequencer command codes
	typedef enum logic [3:0] {
		SAIS_OP_NONE = 4'h0,
		SAIS_OP_PUSH = 4'h1,
		SAIS_OP_POP = 4'h2,
		SAIS_OP_CALL = 4'h3,
		SAIS_OP_RET = 4'h4,
		SAIS_OP_INTERRUPT_EXIT_INSTR = 4'h5,
		SAIS_OP_SEI = 4'h6,
		SAIS_OP_CLI = 4'h7,
		SAIS_OP_OTHER = 4'h8
	} sais_op_t;

	typedef enum logic [3:0] {
		SAIS_ST_RUN = 4'b0001,
		SAIS_ST_ENTRY = 4'b0010,
		SAIS_ST_EXIT = 4'b0100,
		SAIS_ST_WAKE = 4'b1000
	} sais_state_t;

	// One instruction boundary report from the sequencer
	typedef struct packed {
		logic valid;
		sais_op_t op;
		logic busy;
		logic sleeping;
	} sais_instr_t;

	// Register access from the core data path
	typedef struct packed {
		logic wr_sph;
		logic wr_spl;
		logic wr_page;
		logic wr_gie;
		logic wr_vector_table_select;
		logic wr_flag_clr;
		logic [7:0] data;
	} sais_regwr_t;

	// Vector taken and its address
	typedef struct packed {
		logic take;
		logic [15:0] addr;
	} sais_vec_t;
endpackage
`default_nettype wire

/* File: sais_sequencer.sv */
// Stack pointer, page select and interrupt sequencing for the core
`default_nettype none
// Behaviour
// - Single byte push lowers stack pointer by one.
// - Call or interrupt entry lowers stack pointer by two.
// - Single byte pop raises stack pointer by one.
// - Subroutine or interrupt return raises stack pointer by two.
// - Stack pointer is two readable writable bytes, zero after reset.
// - Page bit zero picks program half for extended load and store.
// - Page select bits seven to one read zero; software writes zero.
// - Ordinary program load ignores page select, stays in lower space.
// - Source taken only with own enable and global enable both set.
// - Lowest vector wins; reset highest, external request zero next.
// - Vector table select moves vectors to boot section start.
// - Boot reset fuse moves reset vector to boot section start.
// - Entry clears global enable; interrupt return sets it again.
// - Event flag cleared by hardware when its handler is vectored.
// - Writing one clears a pending flag; zero leaves it.
// - Flags stay pending while disabled, served later by priority.
// - Level sources request only while their condition is present.
// - One instruction runs after interrupt return before next service.
// - Entry and return do not save or restore status flags.
// - Global disable acts at once, even against same cycle request.
// - Instruction after global enable runs before any pending service.
// - Entry takes four cycles, after multicycle end; sleep wake adds four.
// - Interrupt return takes four cycles, pops two bytes, sets enable.
module sais_sequencer (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire sais_pkg::sais_instr_t instr_i,
	input wire sais_pkg::sais_regwr_t regwr_i,
	input wire logic [sais_pkg::NUM_SRC-1:0] src_event_i,
	input wire logic [sais_pkg::NUM_SRC-1:0] src_level_i,
	input wire logic [sais_pkg::NUM_SRC-1:0] src_is_level_i,
	input wire logic [sais_pkg::NUM_SRC-1:0] src_enable_i,
	input wire logic reset_vector_boot_fuse_i,
	input wire logic [15:0] boot_base_i,
	input wire logic ext_load_i,
	input wire logic [15:0] z_pointer_i,
	output logic [7:0] stack_pointer_high_o,
	output logic [7:0] stack_pointer_low_o,
	output logic [7:0] program_page_select_o,
	output logic global_enable_o,
	output logic vector_table_select_o,
	output logic [sais_pkg::NUM_SRC-1:0] pending_o,
	output logic [16:0] prog_addr_o,
	output logic irq_hold_o,
	output sais_pkg::sais_vec_t vector_o,
	output logic [15:0] reset_vector_o
);
	import sais_pkg::*;

	// Index of lowest numbered set request, priority by vector order
	function automatic logic [2:0] lowest_idx(input logic [NUM_SRC-1:0] req);
		logic [2:0] idx;
		idx = 3'(NUM_SRC - 1);
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction

	// Stack pointer step; wraps silently, software keeps the stack in range
	function automatic logic [15:0] sp_move(input logic [15:0] s, input logic [15:0] step, input logic down);
		return down ? s - step : s + step;
	endfunction

	// One decoded instruction at an active boundary
	function automatic logic at_op(input logic bnd, input sais_op_t cur, input sais_op_t want);
		return bnd && cur == want;
	endfunction

	// Architectural state
	logic [15:0] sp_reg;
	logic [7:0] page_reg;
	logic gie_reg;
	logic vector_table_select_reg;
	logic [NUM_SRC-1:0] flag_reg;
	sais_state_t state_reg;
	logic [3:0] cnt_reg;
	logic block_reg;
	logic [2:0] win_reg;
	logic [16:0] paddr_reg;
	sais_vec_t vec_reg;
	logic [15:0] rstvec_reg;

	// Combinational decode and arbitration
	logic [NUM_SRC-1:0] req;
	logic [NUM_SRC-1:0] clr_hw;
	logic boundary;
	logic take;
	logic [2:0] win;
	logic [15:0] vec_base;
	logic op_push;
	logic op_pop;
	logic op_call;
	logic op_ret;
	logic op_interrupt_exit_instr;
	logic op_sei;
	logic op_cli;
	logic hold_next;

	// Boundary of an instruction that is not still in progress
	// multicycle finishes first
	assign boundary = instr_i.valid && !instr_i.busy && state_reg == SAIS_ST_RUN;

	// Instruction decode, only meaningful at an accepted boundary
	assign op_push = at_op(boundary, instr_i.op, SAIS_OP_PUSH);
	assign op_pop = at_op(boundary, instr_i.op, SAIS_OP_POP);
	assign op_call = at_op(boundary, instr_i.op, SAIS_OP_CALL);
	assign op_ret = at_op(boundary, instr_i.op, SAIS_OP_RET);
	assign op_interrupt_exit_instr = at_op(boundary, instr_i.op, SAIS_OP_INTERRUPT_EXIT_INSTR);
	assign op_sei = at_op(boundary, instr_i.op, SAIS_OP_SEI);
	assign op_cli = at_op(boundary, instr_i.op, SAIS_OP_CLI);

	// Request vector: flag or live level, gated by own enable
	// both enables needed
	assign req = ((flag_reg & ~src_is_level_i) | (src_level_i & src_is_level_i)) & src_enable_i;

	// Take decision; CLI in this cycle and the blocking window both veto
	// disable wins same cycle
	assign take = boundary && gie_reg && (req != '0) && !block_reg
		&& instr_i.op != SAIS_OP_CLI && instr_i.op != SAIS_OP_SEI && instr_i.op != SAIS_OP_INTERRUPT_EXIT_INSTR;
	assign win = lowest_idx(req);

	assign vec_base = vector_table_select_reg ? boot_base_i : VEC_BASE_APP;

	// Hardware clear of the flag whose handler is vectored
	// clear on vectoring
	always_comb begin
		clr_hw = '0;
		if (take && !src_is_level_i[win]) begin
			clr_hw[win] = 1'b1;
		end
	end

	// Stack pointer; software write has lowest priority against the sequencer
	// A taken boundary drops its own stack action, the entry push replaces it
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sp_reg <= SP_RESET;
		end else if (take) begin
			sp_reg <= sp_move(sp_reg, SP_TWO, 1'b1);
		end else if (op_push) begin
			sp_reg <= sp_move(sp_reg, SP_ONE, 1'b1);
		end else if (op_pop) begin
			sp_reg <= sp_move(sp_reg, SP_ONE, 1'b0);
		end else if (op_call) begin
			sp_reg <= sp_move(sp_reg, SP_TWO, 1'b1);
		end else if (op_ret || op_interrupt_exit_instr) begin
			sp_reg <= sp_move(sp_reg, SP_TWO, 1'b0);
		end else begin
			if (regwr_i.wr_sph) begin
				sp_reg[15:8] <= regwr_i.data;
			end
			if (regwr_i.wr_spl) begin
				sp_reg[7:0] <= regwr_i.data;
			end
		end
	end

	// Page select; only bit zero is stored
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			page_reg <= PAGE_RESET;
		end else if (regwr_i.wr_page) begin
			page_reg <= regwr_i.data & ~PAGE_RSVD_MASK;
		end
	end

	// Program memory byte address for load and store instructions
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			paddr_reg <= '0;
		end else if (ext_load_i) begin
			paddr_reg <= {page_reg[PAGE_SEL_BIT], z_pointer_i};
		end else begin
			paddr_reg <= {1'b0, z_pointer_i};
		end
	end

	// Global enable bit; status flags other than this are never touched here
	// no status save or restore
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gie_reg <= 1'b0;
		end else if (take) begin
			gie_reg <= 1'b0;
		end else if (op_cli) begin
			gie_reg <= 1'b0;
		end else if (op_sei || op_interrupt_exit_instr) begin
			gie_reg <= 1'b1;
		end else if (regwr_i.wr_gie) begin
			gie_reg <= regwr_i.data[7];
		end
	end

	// Vector table select bit in core control register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vector_table_select_reg <= 1'b0;
		end else if (regwr_i.wr_vector_table_select) begin
			vector_table_select_reg <= regwr_i.data[1];
		end
	end

	// Pending flags; a new event beats any clear in the same cycle
	// write one clears
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= (flag_reg & ~clr_hw & ~(regwr_i.wr_flag_clr ? regwr_i.data : '0))
				| (src_event_i & ~src_is_level_i);
		end
	end

	// Blocks service at the next boundary after SEI or interrupt return
	// return then one instruction
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			block_reg <= 1'b0;
		end else if (boundary) begin
			block_reg <= instr_i.op == SAIS_OP_SEI || instr_i.op == SAIS_OP_INTERRUPT_EXIT_INSTR;
		end else if (state_reg == SAIS_ST_EXIT) begin
			block_reg <= 1'b1;
		end
	end

	// Entry and exit sequencing with cycle counts
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= SAIS_ST_RUN;
			cnt_reg <= '0;
			win_reg <= '0;
		end else begin
			case (state_reg)
				SAIS_ST_RUN: begin
					if (take && instr_i.sleeping) begin
						state_reg <= SAIS_ST_WAKE;
						cnt_reg <= CNT_WAKE - 4'h1;
						win_reg <= win;
					end else if (take) begin
						state_reg <= SAIS_ST_ENTRY;
						cnt_reg <= CNT_ENTRY - 4'h1;
						win_reg <= win;
					end else if (op_interrupt_exit_instr) begin
						state_reg <= SAIS_ST_EXIT;
						cnt_reg <= CNT_EXIT - 4'h1;
					end
				end
				SAIS_ST_WAKE: begin
					if (cnt_reg == '0) begin
						// Wake over, the plain entry sequence follows; the stack push was already done at the take
						state_reg <= SAIS_ST_ENTRY;
						cnt_reg <= CNT_ENTRY - 4'h1;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				SAIS_ST_ENTRY, SAIS_ST_EXIT: begin
					if (cnt_reg == '0) begin
						state_reg <= SAIS_ST_RUN;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				default: begin
					state_reg <= SAIS_ST_RUN;
				end
			endcase
		end
	end

	// Vector output, a registered pulse in the cycle after the last entry cycle
	// lowest vector wins
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vec_reg <= '0;
		end else begin
			vec_reg.take <= state_reg == SAIS_ST_ENTRY && cnt_reg == '0;
			vec_reg.addr <= vec_base + VEC_STRIDE * (16'(win_reg) + 16'h0001);
		end
	end

	// Reset vector selection
	// fuse moves reset vector
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rstvec_reg <= VEC_BASE_APP;
		end else begin
			rstvec_reg <= reset_vector_boot_fuse_i ? boot_base_i : VEC_BASE_APP;
		end
	end

	// Core held from the accepted boundary on, for entry, wake and return alike
	// Drops together with the vector pulse so the handler's first fetch is free
	// return holds from its boundary
	assign hold_next = take || op_interrupt_exit_instr
		|| state_reg == SAIS_ST_WAKE
		|| (state_reg == SAIS_ST_ENTRY && cnt_reg != '0)
		|| (state_reg == SAIS_ST_EXIT && cnt_reg != '0);

	// Registered hold output
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_hold_o <= 1'b0;
		end else begin
			irq_hold_o <= hold_next;
		end
	end

	assign stack_pointer_high_o = sp_reg[15:8];
	assign stack_pointer_low_o = sp_reg[7:0];
	assign program_page_select_o = page_reg;
	assign global_enable_o = gie_reg;
	assign vector_table_select_o = vector_table_select_reg;
	assign pending_o = flag_reg;
	assign prog_addr_o = paddr_reg;
	assign vector_o = vec_reg;
	assign reset_vector_o = rstvec_reg;
endmodule
`default_nettype wire

/* File: sais_seq_properties.sv */
// Concurrent checks on the sequencer's stack, enable and vector outputs
`default_nettype none
module sais_seq_properties (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire sais_pkg::sais_instr_t instr_i,
	input wire sais_pkg::sais_regwr_t regwr_i,
	input wire logic reset_vector_boot_fuse_i,
	input wire logic [15:0] boot_base_i,
	input wire logic ext_load_i,
	input wire logic [15:0] z_pointer_i,
	input wire logic [7:0] stack_pointer_high_o,
	input wire logic [7:0] stack_pointer_low_o,
	input wire logic [7:0] program_page_select_o,
	input wire logic global_enable_o,
	input wire logic [16:0] prog_addr_o,
	input wire logic irq_hold_o,
	input wire sais_pkg::sais_vec_t vector_o,
	input wire logic [15:0] reset_vector_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import sais_pkg::*;
	wire logic [15:0] sp = {stack_pointer_high_o, stack_pointer_low_o};
	wire logic upper = program_page_select_o[PAGE_SEL_BIT];
	// Boundary free of stack writes; with enable off no entry can steal it
	wire logic bnd = instr_i.valid && !instr_i.busy && !irq_hold_o && !regwr_i.wr_sph && !regwr_i.wr_spl;
	wire logic quiet = bnd && !global_enable_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sp_push_a: assert property (quiet && instr_i.op == SAIS_OP_PUSH |=> sp == $past(sp) - SP_ONE)
		else $error("push step wrong");
	sp_pop_a: assert property (quiet && instr_i.op == SAIS_OP_POP |=> sp == $past(sp) + SP_ONE)
		else $error("pop step wrong");
	sp_call_a: assert property (quiet && instr_i.op == SAIS_OP_CALL |=> sp == $past(sp) - SP_TWO)
		else $error("call step wrong");
	sp_ret_a: assert property (quiet && instr_i.op == SAIS_OP_RET |=> sp == $past(sp) + SP_TWO)
		else $error("return step wrong");
	interrupt_exit_instr_exit_a: assert property (bnd && instr_i.op == SAIS_OP_INTERRUPT_EXIT_INSTR |=>
		global_enable_o && sp == $past(sp) + SP_TWO ##0 irq_hold_o [*3] ##1 !irq_hold_o)
		else $error("interrupt return wrong");
	cli_block_a: assert property (bnd && instr_i.op == SAIS_OP_CLI |=> !global_enable_o && !irq_hold_o)
		else $error("request taken after disable");
	entry_time_a: assert property ($rose(irq_hold_o) && $fell(global_enable_o)
		&& !$past(instr_i.sleeping) |-> sp == $past(sp) - SP_TWO ##3 vector_o.take)
		else $error("entry timing wrong");
	wake_entry_a: assert property ($rose(irq_hold_o) && $fell(global_enable_o)
		&& $past(instr_i.sleeping) |-> sp == $past(sp) - SP_TWO ##7 vector_o.take)
		else $error("wake entry timing wrong");
	page_rsvd_a: assert property ((program_page_select_o & PAGE_RSVD_MASK) == 8'h00)
		else $error("reserved page bits set");
	ext_addr_a: assert property (ext_load_i |=> prog_addr_o == {$past(upper), $past(z_pointer_i)})
		else $error("extended address wrong");
	plain_addr_a: assert property (!ext_load_i |=> prog_addr_o == {1'b0, $past(z_pointer_i)})
		else $error("plain load address wrong");
	reset_vec_a: assert property (rstn_i |=>
		reset_vector_o == ($past(reset_vector_boot_fuse_i) ? $past(boot_base_i) : 16'h0000))
		else $error("reset vector wrong");
endmodule
`default_nettype wire

/* File: sais_source_model.sv */
// Peripheral source model: bench requests are registered into event pulses one cycle later
`default_nettype none
module sais_source_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] fire_i,
	output logic [7:0] event_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Launched on an edge so each event is seen exactly once
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			event_o <= 8'h00;
		end else begin
			event_o <= fire_i;
		end
	end
endmodule
`default_nettype wire

/* File: sais_sequencer_bench.sv */
// Self-checking bench for the stack and interrupt sequencer
`default_nettype none
module sais_sequencer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import sais_pkg::*;
	logic clk_i = 1'b0, rstn_i = 1'b0, reset_vector_boot_fuse_i = 1'b0, ext_load_i = 1'b0;
	sais_instr_t instr_i = '0;
	sais_regwr_t regwr_i = '0;
	logic [7:0] fire = 8'h00, src_event_i, src_level_i = 8'h00, src_is_level_i = 8'h00, src_enable_i = 8'h00;
	logic [15:0] boot_base_i = 16'h0000, z_pointer_i = 16'h0000, sp_exp, reset_vector_o;
	logic [7:0] stack_pointer_high_o, stack_pointer_low_o, program_page_select_o, pending_o;
	logic global_enable_o, vector_table_select_o, irq_hold_o;
	logic [16:0] prog_addr_o;
	sais_vec_t vector_o;
	int failures = 0, comparisons = 0, seed = 32'hEE783E80, n;
	logic [31:0] d;
	sais_source_model src (.clk_i, .rstn_i, .fire_i(fire), .event_o(src_event_i));
	sais_sequencer dut (.clk_i, .rstn_i, .instr_i, .regwr_i, .src_event_i, .src_level_i, .src_is_level_i,
		.src_enable_i, .reset_vector_boot_fuse_i, .boot_base_i, .ext_load_i, .z_pointer_i, .stack_pointer_high_o,
		.stack_pointer_low_o, .program_page_select_o, .global_enable_o, .vector_table_select_o, .pending_o,
		.prog_addr_o, .irq_hold_o, .vector_o, .reset_vector_o);
	always #12.5 clk_i = ~clk_i;
	function automatic logic [15:0] sp_step(input sais_op_t o, input logic [15:0] s);
		return o == SAIS_OP_PUSH ? s - 16'h0001 : o == SAIS_OP_POP ? s + 16'h0001 :
			o == SAIS_OP_CALL ? s - 16'h0002 : o == SAIS_OP_RET ? s + 16'h0002 : s;
	endfunction
	function automatic logic [15:0] vec_at(input logic sel, input int i);
		return (sel ? boot_base_i : 16'h0000) + 16'(2 * (i + 1));
	endfunction
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic op_x(input sais_op_t o, input logic bz, input logic sl);
		@(posedge clk_i);
		instr_i <= '{1'b1, o, bz, sl};
		@(posedge clk_i);
		instr_i <= '0;
		#1;
	endtask
	task automatic op(input sais_op_t o);
		op_x(o, 1'b0, 1'b0);
	endtask
	// Strobe mask order: sph, spl, page, gie, vector_table_select, flag clear
	task automatic wr(input logic [5:0] s, input logic [7:0] v);
		@(posedge clk_i);
		regwr_i <= {s, v};
		@(posedge clk_i);
		regwr_i <= '0;
		#1;
	endtask
	task automatic fire_ev(input logic [7:0] m);
		@(posedge clk_i);
		fire <= m;
		@(posedge clk_i);
		fire <= 8'h00;
		@(posedge clk_i);
		#1;
	endtask
	// Entry was launched by the last boundary; follow it through to return
	task automatic serve(input int i, input logic sel, input int w);
		chk_bit(irq_hold_o, 1'b1);
		chk_val({stack_pointer_high_o, stack_pointer_low_o}, 16'h10FD);
		chk_bit(global_enable_o, 1'b0);
		chk_bit(pending_o[i], 1'b0);
		n = 0;
		while (vector_o.take !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk_val(16'(n), 16'(w));
		chk_val(vector_o.addr, vec_at(sel, i));
		op(SAIS_OP_INTERRUPT_EXIT_INSTR);
		chk_val({stack_pointer_high_o, stack_pointer_low_o}, 16'h10FF);
		chk_bit(global_enable_o, 1'b1);
		n = 0;
		while (irq_hold_o !== 1'b0 && n < 20) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk_val(16'(n), 16'(EXIT_CYCLES - 1));
		op(SAIS_OP_OTHER);
		chk_bit(irq_hold_o, 1'b0);
	endtask
	task automatic close_out;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#(25 * 4000);
		failures++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		#1;
		chk_val({stack_pointer_high_o, stack_pointer_low_o}, 16'h0000);
		// Random stack bases, the first crossing a byte boundary
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			sp_exp = (i == 0) ? 16'h0100 : {d[15:8] | 8'h01, d[7:0]};
			wr(6'h20, sp_exp[15:8]);
			wr(6'h10, sp_exp[7:0]);
			chk_val({stack_pointer_high_o, stack_pointer_low_o}, sp_exp);
			op(sais_op_t'(4'(i % 4 + 1)));
			chk_val({stack_pointer_high_o, stack_pointer_low_o}, sp_step(sais_op_t'(4'(i % 4 + 1)), sp_exp));
		end
		$display("stack test done");
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			d[1:0] = 2'(i);
			wr(6'h08, d[7:0]);
			chk_val({8'h00, program_page_select_o}, {15'h0000, d[0]});
			@(posedge clk_i);
			ext_load_i <= d[1];
			z_pointer_i <= d[31:16];
			@(posedge clk_i);
			#1;
			chk_bit(prog_addr_o[16], d[1] & d[0]);
			chk_val(prog_addr_o[15:0], d[31:16]);
		end
		$display("page test done");
		wr(6'h20, 8'h10);
		wr(6'h10, 8'hFF);
		@(posedge clk_i);
		src_is_level_i <= 8'h20;
		src_level_i <= 8'h20;
		fire_ev(8'h0A);
		@(posedge clk_i);
		src_level_i <= 8'h00;
		@(posedge clk_i);
		src_enable_i <= 8'h2A;
		#1;
		chk_val({8'h00, pending_o}, 16'h000A);
		op(SAIS_OP_SEI);
		op(SAIS_OP_OTHER);
		chk_bit(irq_hold_o, 1'b0);
		op(SAIS_OP_PUSH);
		serve(1, 1'b0, ENTRY_CYCLES - 1);
		op(SAIS_OP_OTHER);
		serve(3, 1'b0, ENTRY_CYCLES - 1);
		repeat (3) op(SAIS_OP_OTHER);
		chk_bit(irq_hold_o, 1'b0);
		$display("priority test done");
		d = $random(seed);
		@(posedge clk_i);
		boot_base_i <= {d[15:1], 1'b0};
		wr(6'h02, 8'h02);
		chk_bit(vector_table_select_o, 1'b1);
		fire_ev(8'h42);
		op(SAIS_OP_CLI);
		chk_bit(irq_hold_o, 1'b0);
		chk_bit(global_enable_o, 1'b0);
		wr(6'h01, 8'hBD);
		chk_val({8'h00, pending_o}, 16'h0042);
		op(SAIS_OP_SEI);
		op(SAIS_OP_OTHER);
		op(SAIS_OP_OTHER);
		serve(1, 1'b1, ENTRY_CYCLES - 1);
		chk_val({8'h00, pending_o}, 16'h0040);
		wr(6'h01, 8'h40);
		chk_val({8'h00, pending_o}, 16'h0000);
		// Live level request: refused while busy, then taken from sleep
		@(posedge clk_i);
		src_level_i <= 8'h20;
		op_x(SAIS_OP_PUSH, 1'b1, 1'b0);
		chk_bit(irq_hold_o, 1'b0);
		chk_val({stack_pointer_high_o, stack_pointer_low_o}, 16'h10FF);
		op_x(SAIS_OP_OTHER, 1'b0, 1'b1);
		serve(5, 1'b1, ENTRY_CYCLES + WAKE_CYCLES - 1);
		@(posedge clk_i);
		src_level_i <= 8'h00;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			reset_vector_boot_fuse_i <= 1'(i);
			@(posedge clk_i);
			#1;
			chk_val(reset_vector_o, i ? boot_base_i : 16'h0000);
		end
		$display("vector test done");
		close_out();
	end
endmodule
bind sais_sequencer sais_seq_properties props (.clk_i, .rstn_i, .instr_i, .regwr_i, .reset_vector_boot_fuse_i,
	.boot_base_i, .ext_load_i, .z_pointer_i, .stack_pointer_high_o, .stack_pointer_low_o,
	.program_page_select_o, .global_enable_o, .prog_addr_o, .irq_hold_o, .vector_o, .reset_vector_o);
`default_nettype wire
